// >>> verilog/uart_rx_cfg.svh
// Register offsets, field positions, reset values and timing counts
`ifndef UART_RX_CFG_SVH
`define UART_RX_CFG_SVH

`define ADDR_W 12
`define OFS_COMMAND 12'h000
`define OFS_SETTINGS 12'h004
`define OFS_STATUS 12'h014
`define OFS_HOLDING 12'h018
`define OFS_BAUD_DIV 12'h020

`define CMD_RX_RESET 4
`define CMD_RX_ON 5
`define CMD_RX_OFF 6
`define CMD_CLEAR_STATUS 8

`define SET_PAR_LO 9
`define SET_PAR_HI 11
`define SETTINGS_RESET 3'h0

`define ST_READY 0
`define ST_RX_ON 1
`define ST_OVERRUN 5
`define ST_FRAMING 6
`define ST_PARITY 7

`define DIV_W 17
`define DIV_RESET 17'h00000

`define OVERSAMPLE 5'h10
`define START_LOW_TICKS 4'h7
`define SUB_LAST 4'hf
`define DATA_BITS 3'h7

`endif

// >>> verilog/uart_rx_pkg.sv
// Types shared by the receiver and baud generator
package uart_rx_pkg;
    typedef enum logic [1:0] {
        rx_off,
        rx_idle,
        rx_active
    } rx_mode_type;

    typedef enum {
        ph_start,
        ph_data,
        ph_parity,
        ph_stop
    } rx_phase_type;

    typedef enum logic [2:0] {
        par_even,
        par_odd,
        par_space,
        par_mark,
        par_none
    } parity_sel_type;
endpackage

// >>> verilog/debug_uart_receiver_baud.sv
// Baud generator and asynchronous receiver with APB registers and DMA request
//
// Behaviour
// RL1 - Baud clock is master clock divided by sixteen times the divisor.
// RL2 - Divisor zero stops the baud clock and freezes the serial unit.
// RL3 - Divisor reaches 65536, giving rates from clock/16 down to clock/(16*65536).
// RL4 - Receiver off after reset; receiver-on command starts the start-bit search.
// RL5 - Receiver-off stops at once when idle, else after the current stop bit.
// RL6 - Receiver-reset aborts reception at once and disables, dropping partial data.
// RL7 - Start bit needs line low for more than seven sampling ticks.
// RL8 - Low pulses of seven ticks or fewer are ignored; search continues.
// RL9 - First data sample 24 ticks after falling edge, then every 16.
// RL10 - Asynchronous only, eight data bits with parity, no clock pin; parity settings 4 to 7 receive no parity bit.
// RL11 - One shared baud generator; no receive timeout, no guard time.
// RL12 - Finished character goes to holding register and sets ready flag.
// RL13 - Reading holding register by software or DMA clears ready flag.
// RL14 - Character completing while ready still set raises overrun flag.
// RL15 - Clear-status command clears overrun, parity and framing flags only.
// RL16 - Parity computed per selected type; mismatch sets parity flag with ready.
// RL17 - Parity flag stays set across later characters until clear-status.
// RL18 - Stop bit sampled low sets framing flag together with ready.
// RL19 - Frame is low start, eight data LSB first, optional parity, high stop.
// RL20 - Parity types: odd, even, fixed space, fixed mark.
// RL21 - Ready flag serves as the receive DMA request.
// RL22 - Receive line synchronised to master clock before qualification and sampling.
`include "uart_rx_cfg.svh"

module debug_uart_receiver_baud (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic serial_in_line,
    input wire logic dma_read,
    output logic dma_request,
    output logic [7:0] dma_data,
    output logic baud_tick,
    output uart_rx_pkg::rx_mode_type rx_mode
);
    import uart_rx_pkg::*;

    // Bus decode
    wire logic access_cycle = psel & penable;
    wire logic bus_done = access_cycle & pready;
    wire logic [`ADDR_W-1:0] ofs = paddr[`ADDR_W-1:0];
    wire logic hit_command = ofs == `OFS_COMMAND;
    wire logic hit_settings = ofs == `OFS_SETTINGS;
    wire logic hit_status = ofs == `OFS_STATUS;
    wire logic hit_holding = ofs == `OFS_HOLDING;
    wire logic hit_baud = ofs == `OFS_BAUD_DIV;
    wire logic mapped = hit_command | hit_settings | hit_status | hit_holding | hit_baud;
    wire logic aligned = paddr[1:0] == 2'h0 && paddr[31:`ADDR_W] == '0;
    wire logic addr_ok = mapped & aligned;
    // Reads of write-only command and writes of read-only words are refused
    wire logic access_ok = addr_ok & ~(pwrite & (hit_status | hit_holding))
        & ~(~pwrite & hit_command);
    wire logic wr_done = bus_done & pwrite & access_ok;
    wire logic rd_done = bus_done & ~pwrite & access_ok;
    wire logic cmd_write = wr_done & hit_command;
    wire logic cmd_reset = cmd_write & pwdata[`CMD_RX_RESET];
    wire logic cmd_on = cmd_write & pwdata[`CMD_RX_ON];
    wire logic cmd_off = cmd_write & pwdata[`CMD_RX_OFF];
    wire logic cmd_clear = cmd_write & pwdata[`CMD_CLEAR_STATUS];
    wire logic holding_read = (rd_done & hit_holding) | dma_read; // [RL13]

    logic [`SET_PAR_HI-`SET_PAR_LO:0] parity_sel_reg;
    logic [`DIV_W-1:0] divisor_reg;
    logic [`DIV_W-1:0] presc_reg;
    logic [`DIV_W-1:0] presc_next;
    logic [3:0] baud_sub_reg;
    logic [3:0] baud_sub_next;
    logic sync1_reg;
    logic sync2_reg;
    logic sync3_reg;
    logic line_reg;
    rx_mode_type mode_reg;
    rx_mode_type mode_next;
    rx_phase_type phase_reg;
    rx_phase_type phase_next;
    logic [3:0] tick_cnt_reg;
    logic [3:0] tick_cnt_next;
    logic [2:0] bit_cnt_reg;
    logic [2:0] bit_cnt_next;
    logic [7:0] shift_reg;
    logic [7:0] shift_next;
    logic par_bit_reg;
    logic par_bit_next;
    logic off_pending_reg;
    logic off_pending_next;
    logic [7:0] holding_reg;
    logic ready_reg;
    logic overrun_reg;
    logic parity_err_reg;
    logic framing_reg;
    logic pready_reg;
    logic [31:0] prdata_reg;
    logic pslverr_reg;
    logic baud_tick_reg;

    // Sampling tick at sixteen times the baud rate
    wire logic div_zero = divisor_reg == '0; // [RL2]
    wire logic [`DIV_W-1:0] div_last = divisor_reg - `DIV_W'h1;
    // At or above the limit, so a lowered divisor never waits for a full wrap
    wire logic sample_tick = ~div_zero & (presc_reg >= div_last); // [RL1] [RL3]
    always_comb begin
        presc_next = presc_reg + `DIV_W'h1;
        if (div_zero | sample_tick) begin
            presc_next = '0;
        end
        baud_sub_next = baud_sub_reg;
        if (div_zero) begin
            baud_sub_next = 4'h0;
        end else if (sample_tick) begin
            baud_sub_next = baud_sub_reg + 4'h1;
        end
    end
    // Bit-period pulse offered to the transmitter
    wire logic baud_pulse = sample_tick & (baud_sub_reg == `SUB_LAST); // [RL1] [RL11]

    // Parity expected for the received data
    wire parity_sel_type par_sel = parity_sel_type'(parity_sel_reg);
    wire logic par_used = parity_sel_reg < 3'h4;
    logic par_expect;
    always_comb begin
        par_expect = 1'b0;
        unique case (par_sel)
            par_even: par_expect = ^shift_reg;
            par_odd: par_expect = ~^shift_reg;
            par_space: par_expect = 1'b0;
            par_mark: par_expect = 1'b1;
            default: par_expect = 1'b0;
        endcase
    end // [RL16] [RL20]

    // Receiver sequencing on sampling ticks
    wire logic at_sample = tick_cnt_reg == `SUB_LAST;
    wire logic stop_sampled = mode_reg == rx_active & phase_reg == ph_stop
        & sample_tick & at_sample;
    wire logic char_done = stop_sampled & ~cmd_reset;
    wire logic par_mismatch = par_used & (par_bit_reg != par_expect);
    always_comb begin
        mode_next = mode_reg;
        phase_next = phase_reg;
        tick_cnt_next = tick_cnt_reg;
        bit_cnt_next = bit_cnt_reg;
        shift_next = shift_reg;
        par_bit_next = par_bit_reg;
        off_pending_next = off_pending_reg;
        unique case (mode_reg)
            rx_off: begin
                tick_cnt_next = 4'h0;
                phase_next = ph_start;
                if (cmd_on & ~cmd_off) begin
                    mode_next = rx_idle; // [RL4]
                end
            end
            rx_idle: begin
                if (sample_tick) begin
                    if (line_reg) begin
                        tick_cnt_next = 4'h0; // [RL8]
                    end else if (tick_cnt_reg == `START_LOW_TICKS) begin
                        mode_next = rx_active; // [RL7]
                        phase_next = ph_data;
                        tick_cnt_next = 4'h0;
                        bit_cnt_next = 3'h0;
                    end else begin
                        tick_cnt_next = tick_cnt_reg + 4'h1;
                    end
                end
                if (cmd_off) begin
                    mode_next = rx_off; // [RL5]
                end
            end
            rx_active: begin
                if (cmd_off) begin
                    off_pending_next = 1'b1; // [RL5]
                end
                if (sample_tick) begin
                    tick_cnt_next = tick_cnt_reg + 4'h1; // [RL9]
                    if (at_sample) begin
                        unique case (phase_reg)
                            ph_data: begin
                                shift_next = {line_reg, shift_reg[7:1]}; // [RL19]
                                bit_cnt_next = bit_cnt_reg + 3'h1;
                                if (bit_cnt_reg == `DATA_BITS) begin // [RL10]
                                    phase_next = par_used ? ph_parity : ph_stop;
                                end
                            end
                            ph_parity: begin
                                par_bit_next = line_reg;
                                phase_next = ph_stop;
                            end
                            ph_stop: begin
                                mode_next = (off_pending_reg | cmd_off) ? rx_off : rx_idle;
                                off_pending_next = 1'b0;
                                phase_next = ph_start;
                            end
                            default: phase_next = ph_start;
                        endcase
                    end
                end
            end
            default: mode_next = rx_off;
        endcase
        if (cmd_reset) begin
            mode_next = rx_off; // [RL6]
            phase_next = ph_start;
            off_pending_next = 1'b0;
            tick_cnt_next = 4'h0;
        end
    end

    // Three-stage line capture, level taken when the last two agree
    always_ff @(posedge mclk) begin
        sync1_reg <= serial_in_line; // [RL22]
        sync2_reg <= sync1_reg;
        sync3_reg <= sync2_reg;
        if (!reset_n) begin
            line_reg <= 1'b1;
        end else if (sync2_reg == sync3_reg) begin
            line_reg <= sync3_reg;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            presc_reg <= '0;
            baud_sub_reg <= 4'h0;
            baud_tick_reg <= 1'b0;
        end else begin
            presc_reg <= presc_next;
            baud_sub_reg <= baud_sub_next;
            baud_tick_reg <= baud_pulse;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            mode_reg <= rx_off; // [RL4]
            phase_reg <= ph_start;
            tick_cnt_reg <= 4'h0;
            bit_cnt_reg <= 3'h0;
            shift_reg <= 8'h00;
            par_bit_reg <= 1'b0;
            off_pending_reg <= 1'b0;
        end else begin
            mode_reg <= mode_next;
            phase_reg <= phase_next;
            tick_cnt_reg <= tick_cnt_next;
            bit_cnt_reg <= bit_cnt_next;
            shift_reg <= shift_next;
            par_bit_reg <= par_bit_next;
            off_pending_reg <= off_pending_next;
        end
    end

    // Holding register and sticky flags; a set wins over a clear
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            holding_reg <= 8'h00;
            ready_reg <= 1'b0;
            overrun_reg <= 1'b0;
            parity_err_reg <= 1'b0;
            framing_reg <= 1'b0;
        end else begin
            if (char_done) begin
                holding_reg <= shift_reg; // [RL12]
            end
            ready_reg <= char_done | (ready_reg & ~holding_read); // [RL12] [RL13] [RL21]
            overrun_reg <= (char_done & ready_reg & ~holding_read)
                | (overrun_reg & ~cmd_clear); // [RL14] [RL15]
            parity_err_reg <= (char_done & par_mismatch)
                | (parity_err_reg & ~cmd_clear); // [RL16] [RL17] [RL15]
            framing_reg <= (char_done & ~line_reg)
                | (framing_reg & ~cmd_clear); // [RL18] [RL15]
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            parity_sel_reg <= `SETTINGS_RESET;
            divisor_reg <= `DIV_RESET;
        end else if (wr_done) begin
            if (hit_settings) begin
                parity_sel_reg <= pwdata[`SET_PAR_HI:`SET_PAR_LO];
            end
            if (hit_baud) begin
                divisor_reg <= pwdata[`DIV_W-1:0]; // [RL3]
            end
        end
    end

    // Read data selection
    logic [31:0] status_word;
    logic [31:0] read_word;
    always_comb begin
        status_word = 32'h00000000;
        status_word[`ST_READY] = ready_reg;
        status_word[`ST_RX_ON] = mode_reg != rx_off;
        status_word[`ST_OVERRUN] = overrun_reg;
        status_word[`ST_FRAMING] = framing_reg;
        status_word[`ST_PARITY] = parity_err_reg;
        read_word = 32'h00000000;
        if (hit_settings) begin
            read_word[`SET_PAR_HI:`SET_PAR_LO] = parity_sel_reg;
        end else if (hit_status) begin
            read_word = status_word;
        end else if (hit_holding) begin
            read_word[7:0] = holding_reg;
        end else if (hit_baud) begin
            read_word[`DIV_W-1:0] = divisor_reg;
        end
    end

    // One wait state: answer on the second access-phase edge
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            pready_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg <= access_cycle & ~pready_reg;
            pslverr_reg <= access_cycle & ~pready_reg & ~access_ok;
            if (access_cycle & ~pready_reg & ~pwrite & access_ok) begin
                prdata_reg <= read_word;
            end else if (bus_done) begin
                prdata_reg <= 32'h00000000;
            end
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign dma_request = ready_reg; // [RL21]
    assign dma_data = holding_reg;
    assign baud_tick = baud_tick_reg;
    assign rx_mode = mode_reg;
endmodule

// >>> tb/uart_rx_sva.sv
// Port assertions for the receiver and baud generator, bound to the top
`include "uart_rx_cfg.svh"
module uart_rx_sva (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic serial_in_line,
    input wire logic dma_read,
    input wire logic dma_request,
    input wire logic [7:0] dma_data,
    input wire logic baud_tick,
    input wire uart_rx_pkg::rx_mode_type rx_mode
);
    timeunit 1ns;
    timeprecision 1ps;
    import uart_rx_pkg::*;
    logic [16:0] div_reg;
    logic [21:0] since_reg;
    logic clean_reg;
    wire logic done = psel && penable && pready;
    wire logic wr_ok = done && pwrite && !pslverr;
    wire logic div_wr = wr_ok && paddr[11:0] == `OFS_BAUD_DIV;
    wire logic cmd_wr = wr_ok && paddr[11:0] == `OFS_COMMAND;
    wire logic hold_rd = done && !pwrite && paddr[11:0] == `OFS_HOLDING;
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // Divisor mirror; spacing trusted only after a tick with no divisor write
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            div_reg <= '0;
            clean_reg <= 1'b0;
        end else begin
            if (div_wr) begin
                div_reg <= pwdata[16:0];
            end
            clean_reg <= !div_wr && (clean_reg || baud_tick);
        end
    end
    always_ff @(posedge mclk) begin
        since_reg <= baud_tick ? '0 : since_reg + 22'h1;
    end
    a_reset_off: assert property ($rose(reset_n) |-> rx_mode == rx_off)
        else $error("receiver not off after reset");
    a_on_cmd: assert property (cmd_wr && pwdata[6:4] == 3'b010 && rx_mode == rx_off
        |=> rx_mode == rx_idle) else $error("on command ignored");
    a_off_idle: assert property (cmd_wr && pwdata[6:4] == 3'b100 && rx_mode == rx_idle
        |=> rx_mode == rx_off) else $error("idle receiver not stopped");
    a_reset_cmd: assert property (cmd_wr && pwdata[4] |=> rx_mode == rx_off)
        else $error("receiver reset ignored");
    a_tick_stop: assert property (div_reg == '0 && $past(div_reg) == '0 |-> !baud_tick)
        else $error("tick with divisor zero");
    a_tick_period: assert property (baud_tick && clean_reg
        |-> since_reg == 16 * div_reg - 1) else $error("tick spacing wrong");
    a_ready_fall: assert property ($fell(dma_request)
        |-> $past(dma_read) || $past(hold_rd)) else $error("ready lost without read");
    a_data_ready: assert property ($changed(dma_data) |-> dma_request)
        else $error("holding changed without ready");
    c_char: cover property ($rose(dma_request));
    c_busy_cmd: cover property (cmd_wr && rx_mode == rx_active);
    c_tick: cover property (baud_tick && clean_reg);
endmodule
bind debug_uart_receiver_baud uart_rx_sva u_sva (.mclk(mclk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_in_line(serial_in_line),
    .dma_read(dma_read), .dma_request(dma_request), .dma_data(dma_data),
    .baud_tick(baud_tick), .rx_mode(rx_mode));

// >>> tb/serial_tx_model.sv
// Behavioural remote transmitter driving the receive line
module serial_tx_model (
    input wire logic mclk,
    output logic line
);
    timeunit 1ns;
    timeprecision 1ps;
    initial line = 1'b1;
    task automatic send(input logic [7:0] d, input logic [1:0] par, input logic stop,
        input int bc, input int gap);
        logic [10:0] f;
        f = {stop, par[0], d, 1'b0};
        @(posedge mclk);
        for (int i = 0; i < 11; i++) begin
            if (i != 9 || par[1]) begin
                line <= f[i];
                // Low stop cut short so its tail cannot pass as a start
                repeat ((i == 10 && !stop) ? bc * 3 / 4 : bc) @(posedge mclk);
            end
        end
        line <= 1'b1;
        repeat (gap) @(posedge mclk);
    endtask
    task automatic glitch(input int n);
        @(posedge mclk);
        line <= 1'b0;
        repeat (n) @(posedge mclk);
        line <= 1'b1;
    endtask
endmodule

// >>> tb/testbench.sv
// Self-checking bench for the debug receiver and baud generator
`include "uart_rx_cfg.svh"
`define CHK(n, e, g) comparisons++; if ((g) !== (e)) begin fails++; \
    $display("unexpected %s expected %h seen %h", n, e, g); end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import uart_rx_pkg::*;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic dma_read = 1'b0;
    wire logic serial_in_line;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic dma_request;
    logic [7:0] dma_data;
    logic baud_tick;
    rx_mode_type rx_mode;
    logic [32:0] notes[$];
    logic [32:0] note;
    logic [7:0] b;
    logic [7:0] prev;
    int fails = 0;
    int comparisons = 0;
    localparam int BIT = 32; // Bit time at divisor 2
    always #4 mclk = ~mclk;
    debug_uart_receiver_baud u_dut (
        .mclk(mclk),
        .reset_n(reset_n),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .serial_in_line(serial_in_line),
        .dma_read(dma_read),
        .dma_request(dma_request),
        .dma_data(dma_data),
        .baud_tick(baud_tick),
        .rx_mode(rx_mode)
    );
    serial_tx_model u_tx (.mclk(mclk), .line(serial_in_line));
    task automatic results();
        if (fails == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        input logic [32:0] e);
        notes.push_back(e);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {20'h0, a};
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, {1'b0, e});
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask
    function automatic logic par_of(input logic [2:0] t, input logic [7:0] d);
        return t == 3'h0 ? ^d : t == 3'h1 ? ~^d : t == 3'h3;
    endfunction
    task automatic frame(input logic [2:0] t, input logic bad, input logic stop);
        b = 8'($urandom);
        u_tx.send(b, {t < 3'h4, par_of(t, b) ^ bad}, stop, BIT, 8);
        for (int i = 0; i < 800 && dma_request !== 1'b1; i++) @(posedge mclk);
    endtask
    always @(posedge mclk) begin
        if (psel && penable && pready === 1'b1) begin
            note = notes.pop_front();
            `CHK("bus answer", note, {pslverr, prdata})
        end
    end
    initial begin
        repeat (40000) @(posedge mclk);
        fails++;
        results();
    end
    initial begin
        void'($urandom(32'hf334));
        repeat (16) @(posedge mclk);
        reset_n <= 1'b1;
        rd(`OFS_STATUS, 32'h0);
        rd(`OFS_BAUD_DIV, 32'h0);
        apb(1'b0, 12'h008, 32'h0, {1'b1, 32'h0});
        apb(1'b1, `OFS_STATUS, 32'hff, {1'b1, 32'h0});
        wr(`OFS_BAUD_DIV, 32'h10000);
        rd(`OFS_BAUD_DIV, 32'h10000);
        wr(`OFS_BAUD_DIV, 32'h2);
        wr(`OFS_COMMAND, 32'h20);
        rd(`OFS_STATUS, 32'h2);
        wr(`OFS_BAUD_DIV, 32'h0);
        frame(3'h0, 1'b0, 1'b1);
        rd(`OFS_STATUS, 32'h2);
        wr(`OFS_BAUD_DIV, 32'h2);
        for (int t = 0; t < 5; t++) begin
            wr(`OFS_SETTINGS, t << 9);
            rd(`OFS_SETTINGS, t << 9);
            frame(3'(t), 1'b0, 1'b1);
            rd(`OFS_STATUS, 32'h3);
            rd(`OFS_HOLDING, {24'h0, b});
            rd(`OFS_STATUS, 32'h2);
        end
        wr(`OFS_SETTINGS, 32'h200);
        frame(3'h1, 1'b1, 1'b1);
        rd(`OFS_STATUS, 32'h83);
        frame(3'h1, 1'b0, 1'b1);
        rd(`OFS_STATUS, 32'ha3);
        rd(`OFS_HOLDING, {24'h0, b});
        wr(`OFS_COMMAND, 32'h100);
        rd(`OFS_STATUS, 32'h2);
        frame(3'h1, 1'b0, 1'b0);
        rd(`OFS_STATUS, 32'h43);
        `CHK("dma data", b, dma_data)
        @(posedge mclk);
        dma_read <= 1'b1;
        @(posedge mclk);
        dma_read <= 1'b0;
        @(posedge mclk);
        `CHK("dma request", 1'b0, dma_request)
        wr(`OFS_COMMAND, 32'h100);
        rd(`OFS_STATUS, 32'h2);
        u_tx.glitch(14);
        repeat (600) @(posedge mclk);
        rd(`OFS_STATUS, 32'h2);
        fork
            frame(3'h1, 1'b0, 1'b1);
            begin
                repeat (100) @(posedge mclk);
                wr(`OFS_COMMAND, 32'h40);
            end
        join
        rd(`OFS_STATUS, 32'h1);
        rd(`OFS_HOLDING, {24'h0, b});
        prev = b;
        wr(`OFS_COMMAND, 32'h20);
        fork
            frame(3'h1, 1'b0, 1'b1);
            begin
                repeat (100) @(posedge mclk);
                wr(`OFS_COMMAND, 32'h10);
            end
        join
        rd(`OFS_STATUS, 32'h0);
        rd(`OFS_HOLDING, {24'h0, prev});
        wr(`OFS_COMMAND, 32'h20);
        wr(`OFS_COMMAND, 32'h40);
        rd(`OFS_STATUS, 32'h0);
        results();
    end
endmodule
